// ---- hw/sfx_regs.svh ----
`ifndef SFX_REGS_SVH
`define SFX_REGS_SVH
// ***************************************************************
// Opcodes
// ***************************************************************
`define SFX_OP_DUAL_OUT 8'h3b
`define SFX_OP_QUAD_OUT 8'h6b
`define SFX_OP_DUAL_IO 8'hbb
`define SFX_OP_QUAD_IO 8'heb
`define SFX_OP_PAGE_PGM 8'h02
// ***************************************************************
// Field values and clock counts
// ***************************************************************
`define SFX_MODE_CONT 4'ha
`define SFX_DUMMY_OUT 6'h08
`define SFX_DUMMY_QIO_SPI 6'h04
`define SFX_MODE_CLKS_QPI 6'h02
`define SFX_DUMMY_QPI_4 6'h04
`define SFX_DUMMY_QPI_6 6'h06
`define SFX_DUMMY_QPI_8 6'h08
`define SFX_CMD_BITS 6'h08
`define SFX_ADDR_BITS 6'h18
`define SFX_WRAP_BASE 24'h000008
// ***************************************************************
// Timing
// ***************************************************************
`define SFX_CLK_PERIOD_NS 10
`define SFX_PAGE_PGM_TIME_NS 1000000
`define SFX_PAGE_PGM_CYCLES (`SFX_PAGE_PGM_TIME_NS / `SFX_CLK_PERIOD_NS)
`endif

// ---- hw/sfx_pkg.sv ----
package sfx_pkg;
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_CMD = 8'h02,
		ST_ADDR = 8'h04,
		ST_MODE = 8'h08,
		ST_DUMMY = 8'h10,
		ST_DATA = 8'h20,
		ST_PGM = 8'h40,
		ST_IGNORE = 8'h80
	} sfx_state_e;
	typedef enum logic [2:0] {
		PG_IDLE = 3'h1,
		PG_COMMIT = 3'h2,
		PG_WAIT = 3'h4
	} sfx_pgm_e;
	typedef struct packed {
		logic we;
		logic [7:0] idx;
		logic [7:0] data;
	} sfx_byte_wr_s;
	typedef struct packed {
		logic we;
		logic [23:0] addr;
		logic [7:0] data;
	} sfx_arr_wr_s;
endpackage : sfx_pkg

// ---- hw/sfx_sync.sv ----
`timescale 1ns/10ps
module sfx_sync #(
	parameter int W = 6
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	// ***************************************************************
	// Two-stage synchronisers
	// ***************************************************************
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk) begin
				if (i_sys_rst) begin
					s1_q[g] <= 1'b1;
					s2_q[g] <= 1'b1;
				end else begin
					s1_q[g] <= i_async[g];
					s2_q[g] <= s1_q[g];
				end
			end
		end
	endgenerate
	assign o_sync = s2_q;
endmodule : sfx_sync

// ---- hw/sfx_pgm.sv ----
`timescale 1ns/10ps
`include "sfx_regs.svh"
module sfx_pgm #(
	parameter int P_PGM_CYCLES = 100000
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input sfx_pkg::sfx_byte_wr_s i_wr,
	input wire logic i_clear,
	input wire logic i_start,
	input wire logic [15:0] i_page,
	output logic o_busy,
	output sfx_pkg::sfx_arr_wr_s o_arr_wr
);
	// ***************************************************************
	// Page buffer; only bytes marked in the mask reach the array
	// ***************************************************************
	logic [7:0] buf_q [256];
	logic [255:0] mask_q, mask_d;
	sfx_pkg::sfx_pgm_e st_q, st_d;
	logic [7:0] idx_q, idx_d;
	logic [15:0] page_q, page_d;
	logic [31:0] wait_q, wait_d;
	sfx_pkg::sfx_arr_wr_s wr_q, wr_d;

	always_ff @(posedge i_clk) begin
		if (i_wr.we) begin
			buf_q[i_wr.idx] <= i_wr.data;
		end
	end

	always_comb begin
		st_d = st_q;
		idx_d = idx_q;
		page_d = page_q;
		wait_d = wait_q;
		mask_d = mask_q;
		wr_d = '0;
		if (i_wr.we) begin
			mask_d[i_wr.idx] = 1'b1;
		end
		if (i_clear) begin
			mask_d = '0;
		end
		case (st_q)
			sfx_pkg::PG_IDLE: begin
				if (i_start) begin
					st_d = sfx_pkg::PG_COMMIT;
					page_d = i_page;
					idx_d = 8'h00;
				end
			end
			sfx_pkg::PG_COMMIT: begin
				wr_d.we = mask_q[idx_q];
				wr_d.addr = {page_q, idx_q};
				wr_d.data = buf_q[idx_q];
				idx_d = idx_q + 8'h01;
				if (idx_q == 8'hff) begin
					st_d = sfx_pkg::PG_WAIT;
					wait_d = 32'h0;
					mask_d = '0;
				end
			end
			sfx_pkg::PG_WAIT: begin
				// Self-timed cycle; busy drops only when it expires
				wait_d = wait_q + 32'h1;
				if (wait_q >= 32'(P_PGM_CYCLES - 1)) begin
					st_d = sfx_pkg::PG_IDLE;
				end
			end
			default: st_d = sfx_pkg::PG_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_q <= sfx_pkg::PG_IDLE;
			idx_q <= 8'h00;
			page_q <= 16'h0000;
			wait_q <= 32'h0;
			mask_q <= '0;
			wr_q <= '0;
		end else begin
			st_q <= st_d;
			idx_q <= idx_d;
			page_q <= page_d;
			wait_q <= wait_d;
			mask_q <= mask_d;
			wr_q <= wr_d;
		end
	end

	assign o_busy = (st_q != sfx_pkg::PG_IDLE);
	assign o_arr_wr = wr_q;

	// ***************************************************************
	// Checks
	// ***************************************************************
	property p_commit_masked;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == sfx_pkg::PG_COMMIT && !mask_q[idx_q]) |=> !wr_q.we;
	endproperty
	a_commit_masked: assert property (p_commit_masked)
		else $error("unwritten byte reached the array");
endmodule : sfx_pgm

// ---- hw/sfx_core.sv ----
`timescale 1ns/10ps
`include "sfx_regs.svh"
// Function
// - Dual output read: serial 24-bit address, eight dummy clocks, data on two lines.
// - Quad output read is accepted only with the quad enable bit set.
// - Quad output read: eight dummy clocks after address, data on four lines.
// - Dual I/O read carries a mode byte; upper nibble picks next opcode need.
// - Dual mode nibble A: next dual read starts with address, no opcode.
// - Any other nibble demands a full opcode; mode reset clears it early.
// - Quad I/O read is accepted only with the quad enable bit set.
// - Quad mode nibble A: next transaction is a quad read without opcode.
// - Burst wrap setting enables or disables wrap for quad I/O reads.
// - Wrapped reads circle inside an aligned 8/16/32/64-byte section.
// - Four-wire quad read uses 4, 6 or 8 dummy clocks by parameter.
// - Four-wire continuous mode stays; mode clocks count as dummy clocks.
// - Four-wire quad I/O read never wraps.
// - Page program accepted only with write enable latch set; address then data.
// - Program byte address wraps within the page; extra bytes overwrite.
// - Partial program leaves other page bytes untouched.
// - Select must rise on a byte boundary, else program is discarded.
// - Busy set during program, latch clears at busy, busy ends with cycle.
module sfx_core #(
	parameter int P_PGM_CYCLES = `SFX_PAGE_PGM_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe,
	input wire logic i_quad_enable_bit,
	input wire logic i_four_wire_command_mode,
	input wire logic [1:0] i_read_dummy_sel,
	input wire logic i_wrap_enable,
	input wire logic [1:0] i_wrap_len,
	input wire logic i_write_enable_command,
	input wire logic i_mode_reset,
	output logic o_write_enable_latch,
	output logic o_busy,
	output logic [23:0] o_rd_addr,
	input wire logic [7:0] i_rd_data,
	output sfx_pkg::sfx_arr_wr_s o_arr_wr
);
	// ***************************************************************
	// Pin sampling and edge detection
	// ***************************************************************
	logic [5:0] pins_s;
	logic sck_p_q;
	logic cs_p_q;
	logic sck_rise, sck_fall, cs_rise, cs_fall;
	logic [3:0] io_s;

	sfx_sync #(.W(6)) u_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({i_cs_n, i_sck, i_io}),
		.o_sync(pins_s)
	);

	assign io_s = pins_s[3:0];
	assign sck_rise = pins_s[4] & ~sck_p_q;
	assign sck_fall = ~pins_s[4] & sck_p_q;
	assign cs_rise = pins_s[5] & ~cs_p_q;
	assign cs_fall = ~pins_s[5] & cs_p_q;

	// ***************************************************************
	// Decoding helpers
	// ***************************************************************
	function automatic logic [1:0] lane_shift(input sfx_pkg::sfx_state_e st,
		input logic [7:0] cmd, input logic four_wire_command_mode);
		lane_shift = 2'h0;
		if (four_wire_command_mode) begin
			lane_shift = 2'h2;
		end else if (st != sfx_pkg::ST_CMD && cmd == `SFX_OP_DUAL_IO) begin
			lane_shift = 2'h1;
		end else if (st != sfx_pkg::ST_CMD && cmd == `SFX_OP_QUAD_IO) begin
			lane_shift = 2'h2;
		end
	endfunction : lane_shift

	function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap,
		input logic [1:0] len);
		logic [23:0] m;
		m = (`SFX_WRAP_BASE << len) - 24'h000001;
		next_addr = a + 24'h000001;
		if (wrap) begin
			next_addr = (a & ~m) | ((a + 24'h000001) & m);
		end
	endfunction : next_addr

	// ***************************************************************
	// Transaction sequencer
	// ***************************************************************
	sfx_pkg::sfx_state_e st_q, st_d;
	logic [7:0] cmd_q, cmd_d;
	logic [5:0] cnt_q, cnt_d;
	logic [5:0] dum_q, dum_d;
	logic [31:0] sh_q, sh_d;
	logic [23:0] addr_q, addr_d;
	logic [7:0] out_q, out_d;
	logic [3:0] io_q, io_d;
	logic [3:0] oe_q, oe_d;
	logic cont_q, cont_d;
	logic cont_quad_q, cont_quad_d;
	logic qpi_q, qpi_d;
	logic wrap_q, wrap_d;
	logic [1:0] wlen_q, wlen_d;
	logic wel_q, wel_d;
	logic got_byte_q, got_byte_d;
	logic pgm_start, pgm_clear;
	sfx_pkg::sfx_byte_wr_s pw;
	logic [1:0] ls;
	logic [1:0] ols;
	logic [5:0] tgt;
	logic [5:0] qpi_dum;

	always_comb begin
		ls = lane_shift(st_q, cmd_q, qpi_q);
		ols = (qpi_q || cmd_q == `SFX_OP_QUAD_OUT || cmd_q == `SFX_OP_QUAD_IO) ? 2'h2 : 2'h1;
		case (st_q)
			sfx_pkg::ST_ADDR: tgt = `SFX_ADDR_BITS >> ls;
			sfx_pkg::ST_DUMMY: tgt = dum_q;
			sfx_pkg::ST_DATA: tgt = `SFX_CMD_BITS >> ols;
			default: tgt = `SFX_CMD_BITS >> ls;
		endcase
		case (i_read_dummy_sel)
			2'h0: qpi_dum = `SFX_DUMMY_QPI_4;
			2'h1: qpi_dum = `SFX_DUMMY_QPI_6;
			default: qpi_dum = `SFX_DUMMY_QPI_8;
		endcase
	end

	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		cnt_d = cnt_q;
		dum_d = dum_q;
		sh_d = sh_q;
		addr_d = addr_q;
		out_d = out_q;
		io_d = io_q;
		oe_d = oe_q;
		cont_d = cont_q;
		cont_quad_d = cont_quad_q;
		qpi_d = qpi_q;
		wrap_d = wrap_q;
		wlen_d = wlen_q;
		got_byte_d = got_byte_q;
		pgm_start = 1'b0;
		pgm_clear = 1'b0;
		pw = '0;
		// Clear first, so a mode byte landing with the reset pulse still sets
		if (i_mode_reset) begin
			cont_d = 1'b0;
		end
		if (cs_rise) begin
			if (st_q == sfx_pkg::ST_PGM && cnt_q == 6'h00 && got_byte_q) begin
				pgm_start = 1'b1;
			end else if (st_q == sfx_pkg::ST_PGM) begin
				pgm_clear = 1'b1;
			end
			st_d = sfx_pkg::ST_IDLE;
			oe_d = 4'h0;
		end else if (cs_fall) begin
			cnt_d = 6'h00;
			qpi_d = i_four_wire_command_mode;
			if (o_busy) begin
				st_d = sfx_pkg::ST_IGNORE;
			end else if (cont_q && (!cont_quad_q || i_quad_enable_bit)) begin
				st_d = sfx_pkg::ST_ADDR;
				cmd_d = cont_quad_q ? `SFX_OP_QUAD_IO : `SFX_OP_DUAL_IO;
			end else begin
				st_d = sfx_pkg::ST_CMD;
			end
		end else if (sck_rise && st_q != sfx_pkg::ST_DATA && st_q != sfx_pkg::ST_IDLE) begin
			// MSB first, highest line carries the top bit of each group
			case (ls)
				2'h0: sh_d = {sh_q[30:0], io_s[0]};
				2'h1: sh_d = {sh_q[29:0], io_s[1:0]};
				default: sh_d = {sh_q[27:0], io_s[3:0]};
			endcase
			cnt_d = cnt_q + 6'h01;
			if (cnt_q + 6'h01 == tgt) begin
				cnt_d = 6'h00;
				case (st_q)
					sfx_pkg::ST_CMD: begin
						cmd_d = sh_d[7:0];
						st_d = sfx_pkg::ST_IGNORE;
						case (sh_d[7:0])
							`SFX_OP_DUAL_OUT: if (!qpi_q) st_d = sfx_pkg::ST_ADDR;
							`SFX_OP_QUAD_OUT: if (!qpi_q && i_quad_enable_bit) st_d = sfx_pkg::ST_ADDR;
							`SFX_OP_DUAL_IO: if (!qpi_q) st_d = sfx_pkg::ST_ADDR;
							`SFX_OP_QUAD_IO: if (i_quad_enable_bit) st_d = sfx_pkg::ST_ADDR;
							`SFX_OP_PAGE_PGM: if (wel_q) st_d = sfx_pkg::ST_ADDR;
							default: st_d = sfx_pkg::ST_IGNORE;
						endcase
					end
					sfx_pkg::ST_ADDR: begin
						addr_d = sh_d[23:0];
						// Wrap only for quad I/O reads in single-line command mode
						wrap_d = cmd_q == `SFX_OP_QUAD_IO && !qpi_q && i_wrap_enable;
						wlen_d = i_wrap_len;
						if (cmd_q == `SFX_OP_DUAL_IO || cmd_q == `SFX_OP_QUAD_IO) begin
							st_d = sfx_pkg::ST_MODE;
						end else if (cmd_q == `SFX_OP_PAGE_PGM) begin
							st_d = sfx_pkg::ST_PGM;
							got_byte_d = 1'b0;
						end else begin
							st_d = sfx_pkg::ST_DUMMY;
							dum_d = `SFX_DUMMY_OUT;
						end
					end
					sfx_pkg::ST_MODE: begin
						cont_d = sh_d[7:4] == `SFX_MODE_CONT;
						cont_quad_d = cmd_q == `SFX_OP_QUAD_IO;
						dum_d = 6'h00;
						if (cmd_q == `SFX_OP_QUAD_IO) begin
							dum_d = qpi_q ? qpi_dum - `SFX_MODE_CLKS_QPI : `SFX_DUMMY_QIO_SPI;
						end
						st_d = (dum_d == 6'h00) ? sfx_pkg::ST_DATA : sfx_pkg::ST_DUMMY;
					end
					sfx_pkg::ST_DUMMY: st_d = sfx_pkg::ST_DATA;
					sfx_pkg::ST_PGM: begin
						pw.we = 1'b1;
						pw.idx = addr_q[7:0];
						pw.data = sh_d[7:0];
						addr_d[7:0] = addr_q[7:0] + 8'h01;
						got_byte_d = 1'b1;
					end
					default: st_d = st_q;
				endcase
			end
		end else if (sck_fall && st_q == sfx_pkg::ST_DATA) begin
			if (cnt_q == 6'h00) begin
				out_d = i_rd_data;
				addr_d = next_addr(addr_q, wrap_q, wlen_q);
			end else begin
				out_d = out_q << (ols == 2'h1 ? 2 : 4);
			end
			io_d = (ols == 2'h1) ? {2'b00, out_d[7:6]} : out_d[7:4];
			oe_d = (ols == 2'h1) ? 4'h3 : 4'hf;
			cnt_d = (cnt_q + 6'h01 == tgt) ? 6'h00 : cnt_q + 6'h01;
		end
		// Set wins over the clear when both land in one cycle
		wel_d = wel_q;
		if (pgm_start) begin
			wel_d = 1'b0;
		end
		if (i_write_enable_command) begin
			wel_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_q <= sfx_pkg::ST_IDLE;
			cmd_q <= 8'h00;
			cnt_q <= 6'h00;
			dum_q <= 6'h00;
			sh_q <= 32'h0;
			addr_q <= 24'h000000;
			out_q <= 8'h00;
			io_q <= 4'h0;
			oe_q <= 4'h0;
			cont_q <= 1'b0;
			cont_quad_q <= 1'b0;
			qpi_q <= 1'b0;
			wrap_q <= 1'b0;
			wlen_q <= 2'h0;
			wel_q <= 1'b0;
			got_byte_q <= 1'b0;
			sck_p_q <= 1'b1;
			cs_p_q <= 1'b1;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			cnt_q <= cnt_d;
			dum_q <= dum_d;
			sh_q <= sh_d;
			addr_q <= addr_d;
			out_q <= out_d;
			io_q <= io_d;
			oe_q <= oe_d;
			cont_q <= cont_d;
			cont_quad_q <= cont_quad_d;
			qpi_q <= qpi_d;
			wrap_q <= wrap_d;
			wlen_q <= wlen_d;
			wel_q <= wel_d;
			got_byte_q <= got_byte_d;
			sck_p_q <= pins_s[4];
			cs_p_q <= pins_s[5];
		end
	end

	// ***************************************************************
	// Page buffer and self-timed program cycle
	// ***************************************************************
	sfx_pgm #(.P_PGM_CYCLES(P_PGM_CYCLES)) u_pgm (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_wr(pw),
		.i_clear(pgm_clear),
		.i_start(pgm_start),
		.i_page(addr_q[23:8]),
		.o_busy(o_busy),
		.o_arr_wr(o_arr_wr)
	);

	assign o_io = io_q;
	assign o_io_oe = oe_q;
	assign o_rd_addr = addr_q;
	assign o_write_enable_latch = wel_q;

	// ***************************************************************
	// Checks
	// ***************************************************************
	logic [5:0] dum_seen_q;
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || st_q != sfx_pkg::ST_DUMMY) begin
			dum_seen_q <= 6'h00;
		end else if (sck_rise) begin
			dum_seen_q <= dum_seen_q + 6'h01;
		end
	end

	property p_out_dummy;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == sfx_pkg::ST_DUMMY && st_d == sfx_pkg::ST_DATA && !qpi_q &&
		(cmd_q == `SFX_OP_DUAL_OUT || cmd_q == `SFX_OP_QUAD_OUT)) |-> dum_seen_q == 6'h07;
	endproperty
	a_out_dummy: assert property (p_out_dummy)
		else $error("output read did not wait eight dummy clocks");

	property p_quad_gate;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == sfx_pkg::ST_CMD && st_d == sfx_pkg::ST_ADDR &&
		(cmd_d == `SFX_OP_QUAD_OUT || cmd_d == `SFX_OP_QUAD_IO)) |-> i_quad_enable_bit;
	endproperty
	a_quad_gate: assert property (p_quad_gate)
		else $error("quad read accepted without quad enable");

	property p_cont_entry;
		@(posedge i_clk) disable iff (i_sys_rst)
		(cs_fall && cont_q && !cont_quad_q && !o_busy) |=> st_q == sfx_pkg::ST_ADDR &&
		cmd_q == `SFX_OP_DUAL_IO;
	endproperty
	a_cont_entry: assert property (p_cont_entry)
		else $error("continuous dual read did not skip the opcode");

	property p_cont_drop;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == sfx_pkg::ST_MODE && st_d != sfx_pkg::ST_MODE && !cs_rise &&
		sh_d[7:4] != `SFX_MODE_CONT) |=> !cont_q;
	endproperty
	a_cont_drop: assert property (p_cont_drop)
		else $error("mode byte without A left continuous mode on");

	property p_oe_data;
		@(posedge i_clk) disable iff (i_sys_rst)
		(o_io_oe != 4'h0) |-> st_q == sfx_pkg::ST_DATA;
	endproperty
	a_oe_data: assert property (p_oe_data)
		else $error("IO driven outside data phase");

	property p_no_wrap_qpi;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == sfx_pkg::ST_DATA && qpi_q) |-> !wrap_q;
	endproperty
	a_no_wrap_qpi: assert property (p_no_wrap_qpi)
		else $error("wrap active in four-wire command mode");

	property p_wrap_stay;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == sfx_pkg::ST_DATA && wrap_q && $changed(addr_q)) |->
		addr_q[23:6] == $past(addr_q[23:6]);
	endproperty
	a_wrap_stay: assert property (p_wrap_stay)
		else $error("wrapped read left its section");

	property p_pgm_gate;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == sfx_pkg::ST_CMD && st_d == sfx_pkg::ST_ADDR &&
		cmd_d == `SFX_OP_PAGE_PGM) |-> wel_q;
	endproperty
	a_pgm_gate: assert property (p_pgm_gate)
		else $error("page program accepted without write enable latch");

	property p_partial_discard;
		@(posedge i_clk) disable iff (i_sys_rst)
		(cs_rise && st_q == sfx_pkg::ST_PGM && cnt_q != 6'h00 && !o_busy) |=> !o_busy [*3];
	endproperty
	a_partial_discard: assert property (p_partial_discard)
		else $error("program started off a byte boundary");

	property p_busy_wel;
		@(posedge i_clk) disable iff (i_sys_rst)
		($rose(o_busy) && !$past(i_write_enable_command) && !i_write_enable_command) |-> !wel_q;
	endproperty
	a_busy_wel: assert property (p_busy_wel)
		else $error("write enable latch not cleared at busy");

	property p_page_wrap;
		@(posedge i_clk) disable iff (i_sys_rst)
		pw.we |=> addr_q[7:0] == $past(pw.idx) + 8'h01 && addr_q[23:8] == $past(addr_q[23:8]);
	endproperty
	a_page_wrap: assert property (p_page_wrap)
		else $error("program address left the page");
endmodule : sfx_core

// ---- bench/sfx_host.sv ----
`timescale 1ns/10ps
// ***************************************************************
// Host serial controller model, clock idles low
// ***************************************************************
module sfx_host (
	input wire logic [3:0] i_io,
	output logic o_sck,
	output logic o_cs_n,
	output logic [3:0] o_io
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'h0;
	end
	// Lines change while the clock is low; a released line inverts each clock, never stale
	task automatic bits(input int n, input int l, input logic [31:0] v, input bit drv,
		output logic [31:0] r);
		logic [3:0] m;
		m = 4'((5'h01 << l) - 5'h01);
		r = 32'h00000000;
		for (int k = 0; k < n; k++) begin
			if (drv) begin
				o_io = 4'(v >> ((n - 1 - k) * l)) & m;
			end else begin
				o_io = ~o_io;
			end
			#62.5;
			r = (r << l) | 32'(i_io & m);
			o_sck = 1'b1;
			#62.5;
			o_sck = 1'b0;
		end
	endtask : bits
	// Opcode lanes 0 skips the opcode; mode slot also carries program data
	task automatic frame(input logic [7:0] op, input int ol, input logic [23:0] a, input int al,
		input int mc, input logic [31:0] md, input int dc, input int rc, input int rl,
		output logic [31:0] r);
		logic [31:0] x;
		o_cs_n = 1'b0;
		#100;
		if (ol > 0) begin
			bits(8 / ol, ol, 32'(op), 1'b1, x);
		end
		bits(24 / al, al, 32'(a), 1'b1, x);
		bits(mc, al, md, 1'b1, x);
		bits(dc, 1, 32'h00000000, 1'b0, x);
		bits(rc, rl, 32'h00000000, 1'b0, r);
		#100;
		o_cs_n = 1'b1;
		#300;
	endtask : frame
endmodule : sfx_host

// ---- bench/sfx_core_tb_top.sv ----
`timescale 1ns/10ps
`include "sfx_regs.svh"
module sfx_core_tb_top;
	logic clk, rst, sck, cs_n, qe, fw, wen, wec, mrst, write_enable_latch, busy;
	logic [3:0] h_io, io_w, o_io, oe, oe_seen;
	logic [1:0] dsel, wlen;
	logic [23:0] rd_addr;
	logic [7:0] rd_data;
	sfx_pkg::sfx_arr_wr_s arr;
	logic [7:0] wmem [512];
	logic [31:0] r;
	logic busy_seen, cs_q;
	int fail_count = 0;
	int cmp_count = 0;
	int wr_n = 0;
	int cyc = 0;
	// Wire level: device drives where enabled, host elsewhere
	assign io_w = (oe & o_io) | (~oe & h_io);
	assign rd_data = rd_addr[7:0] ^ 8'h5a;
	sfx_host sfx_host_inst (.i_io(io_w), .o_sck(sck), .o_cs_n(cs_n), .o_io(h_io));
	sfx_core #(.P_PGM_CYCLES(50)) sfx_core_inst (.i_clk(clk), .i_sys_rst(rst), .i_sck(sck),
		.i_cs_n(cs_n), .i_io(io_w), .o_io(o_io), .o_io_oe(oe), .i_quad_enable_bit(qe),
		.i_four_wire_command_mode(fw), .i_read_dummy_sel(dsel), .i_wrap_enable(wen),
		.i_wrap_len(wlen), .i_write_enable_command(wec), .i_mode_reset(mrst),
		.o_write_enable_latch(write_enable_latch), .o_busy(busy), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
		.o_arr_wr(arr));
	always #5 clk = ~clk;
	// ***************************************************************
	// Monitors and timeout
	// ***************************************************************
	always @(posedge clk) begin
		cyc <= cyc + 1;
		cs_q <= cs_n;
		// A new frame restarts the per-frame records
		if (cs_q && !cs_n) begin
			oe_seen <= oe;
			busy_seen <= busy;
		end else begin
			oe_seen <= oe_seen | oe;
			busy_seen <= busy_seen | busy;
		end
		if (arr.we === 1'b1) begin
			wr_n <= wr_n + 1;
			wmem[arr.addr[8:0]] <= arr.data;
		end
		if (cyc == 80000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic frm(input logic [7:0] op, input int ol, input logic [23:0] a, input int al,
		input int mc, input logic [31:0] md, input int dc, input int rc, input int rl);
		@(negedge clk);
		sfx_host_inst.frame(op, ol, a, al, mc, md, dc, rc, rl, r);
	endtask : frm
	function automatic logic [7:0] ev(input logic [23:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction : ev
	function automatic logic [31:0] e2(input logic [23:0] a);
		return {16'h0000, ev(a), ev(a + 24'h000001)};
	endfunction : e2
	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{qe, fw, wen, wec, mrst, dsel, wlen} = 9'h000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		frm(`SFX_OP_DUAL_OUT, 1, 24'h000010, 1, 0, 0, 8, 8, 2);
		chk(r, e2(24'h000010));
		chk(32'(oe_seen), 32'h3);
		frm(`SFX_OP_QUAD_OUT, 1, 24'h000020, 1, 0, 0, 8, 4, 4);
		chk(32'(oe_seen), 32'h0);
		frm(`SFX_OP_QUAD_IO, 1, 24'h000020, 4, 2, 0, 4, 4, 4);
		chk(32'(oe_seen), 32'h0);
		@(posedge clk) qe <= 1'b1;
		frm(`SFX_OP_QUAD_OUT, 1, 24'h000020, 1, 0, 0, 8, 4, 4);
		chk(r, e2(24'h000020));
		chk(32'(oe_seen), 32'hf);
		frm(`SFX_OP_DUAL_IO, 1, 24'h000030, 2, 4, 32'ha5, 0, 8, 2);
		chk(r, e2(24'h000030));
		frm(8'h00, 0, 24'h000040, 2, 4, 32'ha0, 0, 8, 2);
		chk(r, e2(24'h000040));
		@(posedge clk) mrst <= 1'b1;
		@(posedge clk) mrst <= 1'b0;
		frm(`SFX_OP_DUAL_IO, 1, 24'h000050, 2, 4, 32'h50, 0, 8, 2);
		chk(r, e2(24'h000050));
		frm(`SFX_OP_DUAL_IO, 1, 24'h000060, 2, 4, 32'h00, 0, 8, 2);
		chk(r, e2(24'h000060));
		// Wrap within an 8-byte and a 16-byte section
		@(posedge clk) wen <= 1'b1;
		frm(`SFX_OP_QUAD_IO, 1, 24'h000106, 4, 2, 0, 4, 8, 4);
		chk(r, {e2(24'h000106) << 16} | e2(24'h000100));
		@(posedge clk) wlen <= 2'h1;
		frm(`SFX_OP_QUAD_IO, 1, 24'h00010e, 4, 2, 0, 4, 8, 4);
		chk(r, {e2(24'h00010e) << 16} | e2(24'h000100));
		// Four-wire mode: every dummy setting, wrap still requested but never applied
		@(posedge clk) fw <= 1'b1;
		for (int s = 0; s < 3; s++) begin
			@(posedge clk) dsel <= 2'(s);
			frm(`SFX_OP_QUAD_IO, 4, 24'h00020e, 4, 2, 0, 2 + 2 * s, 8, 4);
			chk(r, {e2(24'h00020e) << 16} | e2(24'h000210));
		end
		@(posedge clk) fw <= 1'b0;
		// Page program: refused without latch, then wrapped 3 bytes, then off-boundary
		frm(`SFX_OP_PAGE_PGM, 1, 24'h0001fe, 1, 24, 32'h112233, 0, 0, 1);
		chk(32'(busy_seen), 32'h0);
		@(posedge clk) wec <= 1'b1;
		@(posedge clk) wec <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(write_enable_latch), 32'h1);
		frm(`SFX_OP_PAGE_PGM, 1, 24'h0001fe, 1, 24, 32'h112233, 0, 0, 1);
		chk(32'(busy), 32'h1);
		chk(32'(write_enable_latch), 32'h0);
		for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
		chk(32'(busy), 32'h0);
		chk(32'(wr_n), 32'h3);
		chk({wmem[9'h1fe], wmem[9'h1ff], wmem[9'h100]}, 32'h112233);
		@(posedge clk) wec <= 1'b1;
		@(posedge clk) wec <= 1'b0;
		frm(`SFX_OP_PAGE_PGM, 1, 24'h000300, 1, 12, 32'habc, 0, 0, 1);
		repeat (20) @(posedge clk);
		chk({31'h0, busy_seen}, 32'h0);
		chk(32'(wr_n), 32'h3);
		print_verdict();
	end
endmodule : sfx_core_tb_top
